/* File: src/osdcd_top.sv */
// Serial command decoder of the on-screen display controller.
`timescale 1ns/10ps
module osdcd_top #(
    parameter int ERASE_CYC  = osdcd_pkg::ERASE_CYCLES,
    parameter int BLINK_SHORT = osdcd_pkg::BLINK_SHORT_HALF,
    parameter int BLINK_LONG  = osdcd_pkg::BLINK_LONG_HALF
) (
    // Core clock, reset and enable
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // Serial command pins
    input  wire logic       link_clk_in,
    input  wire logic       cs_n_in,
    input  wire logic       sdata_in,
    // Display memory read port
    input  wire logic [8:0] rd_addr_in,
    output logic      [7:0] rd_data_out,
    // Address state
    output logic      [3:0] row_addr_out,
    output logic      [4:0] col_addr_out,
    // Vertical and horizontal settings
    output logic      [1:0] first_line_vsize_out,
    output logic      [1:0] second_line_vsize_out,
    output logic      [6:0] vertical_start_out,
    output logic            crystal_rate_select_out,
    output logic      [1:0] first_line_hsize_out,
    output logic      [1:0] second_line_hsize_out,
    output logic      [6:0] horizontal_start_out,
    output logic            dot_clock_select_out,
    // System and display control
    output logic            osc_stop_enable_out,
    output logic            test_mode_bit_out,
    output logic            display_enable_out,
    output logic            reverse_enable_out,
    output logic            blink_enable_out,
    output logic            blink_period_select_out,
    output logic      [1:0] blank_area_out,
    output logic            blank_video_select_out,
    output logic            blink_phase_out,
    output logic            erase_busy_out,
    // Sync mode
    output logic            int_sync_out,
    output logic            noninterlace_out,
    output logic      [1:0] tv_standard_out
);

    // ==========================================================
    // Link domain: shift register on the serial clock
    logic       lk_clr;
    logic [2:0] bit_cnt;
    logic [6:0] shreg;
    logic [7:0] lk_byte;
    logic       lk_tog;

    // The bit counter is cleared whenever the enable is high, so a
    // broken unit never shifts into the next frame.
    assign lk_clr = rst_in | cs_n_in;

    always_ff @(posedge link_clk_in or posedge lk_clr) begin
        if (lk_clr) begin
            bit_cnt <= 3'h0;
            shreg   <= 7'h00;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            shreg   <= {shreg[5:0], sdata_in};
        end
    end

    // The finished unit is held until the next one, at least eight
    // serial clocks later, which leaves ample time for the crossing.
    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lk_byte <= 8'h00;
            lk_tog  <= 1'b0;
        end else if (bit_cnt == 3'h7) begin
            lk_byte <= {shreg, sdata_in};
            lk_tog  <= ~lk_tog;
        end
    end

    a_unit_done: assert property (
        @(posedge link_clk_in) disable iff (lk_clr)
        bit_cnt == 3'h7 |=> lk_tog != $past(lk_tog)
    ) else $error("unit not released after eighth bit");

    // ==========================================================
    // Crossing into the core domain
    logic cs_s1;
    logic cs_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic byte_stb;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else if (ce_in) begin
            cs_s1  <= cs_n_in;
            cs_s2  <= cs_s1;
            tog_s1 <= lk_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    assign byte_stb = ce_in && (tog_s2 != tog_s3);

    // ==========================================================
    // Unit decoding
    osdcd_pkg::osdcd_cmd_e cmd;
    osdcd_pkg::osdcd_cmd_e rx_id;
    logic [7:0] rx;
    logic       first_unit;
    logic       second_unit;
    logic       soft_rst;
    logic       erase_go;
    logic       char_wr;

    assign rx    = lk_byte;
    assign rx_id = osdcd_pkg::osdcd_cmd_e'(rx[osdcd_pkg::ID_MSB:osdcd_pkg::ID_LSB]);
    // In character mode every unit is data, whatever its top bit.
    assign first_unit  = byte_stb && !cs_s2 && rx[osdcd_pkg::UNIT_FLAG_BIT]
                         && cmd != osdcd_pkg::OSDCD_CHAR;
    assign second_unit = byte_stb && !cs_s2 && (!rx[osdcd_pkg::UNIT_FLAG_BIT]
                         || cmd == osdcd_pkg::OSDCD_CHAR);
    assign soft_rst    = first_unit && rx_id == osdcd_pkg::OSDCD_CTRL
                         && rx[osdcd_pkg::SRST_BIT];
    assign erase_go    = first_unit && rx_id == osdcd_pkg::OSDCD_CTRL
                         && rx[osdcd_pkg::ERASE_BIT];
    assign char_wr     = second_unit && cmd == osdcd_pkg::OSDCD_CHAR;

    function automatic logic [8:0] mem_addr(input logic [3:0] r, input logic [4:0] c);
        mem_addr = 9'({5'h00, r} * osdcd_pkg::ROW_WORDS) + {4'h0, c};
    endfunction
    function automatic logic addr_ok(input logic [3:0] r, input logic [4:0] c);
        addr_ok = (r <= osdcd_pkg::ROW_LAST) && (c <= osdcd_pkg::COL_LAST);
    endfunction

    // ==========================================================
    // Kept command and write address
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd <= osdcd_pkg::OSDCD_ADDR;
        end else if (ce_in) begin
            if (cs_s2) begin
                cmd <= osdcd_pkg::OSDCD_ADDR;
            end else if (first_unit) begin
                cmd <= rx_id;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            row_addr_out <= 4'h0;
            col_addr_out <= 5'h00;
        end else if (ce_in) begin
            if (soft_rst) begin
                row_addr_out <= 4'h0;
                col_addr_out <= 5'h00;
            end else if (first_unit && rx_id == osdcd_pkg::OSDCD_ADDR) begin
                row_addr_out <= rx[3:0];
            end else if (second_unit && cmd == osdcd_pkg::OSDCD_ADDR) begin
                col_addr_out <= rx[4:0];
            end else if (char_wr && !erase_busy_out) begin
                if (col_addr_out >= osdcd_pkg::COL_LAST) begin
                    col_addr_out <= 5'h00;
                    row_addr_out <= (row_addr_out >= osdcd_pkg::ROW_LAST) ? 4'h0
                                    : row_addr_out + 4'h1;
                end else begin
                    col_addr_out <= col_addr_out + 5'h01;
                end
            end
        end
    end

    // ==========================================================
    // Vertical and horizontal settings
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in || (ce_in && soft_rst)) begin
            first_line_vsize_out    <= 2'h0;
            second_line_vsize_out   <= 2'h0;
            vertical_start_out      <= 7'h00;
            crystal_rate_select_out <= 1'b0;
            first_line_hsize_out    <= 2'h0;
            second_line_hsize_out   <= 2'h0;
            horizontal_start_out    <= 7'h00;
            dot_clock_select_out    <= 1'b0;
        end else if (ce_in) begin
            if (first_unit && rx_id == osdcd_pkg::OSDCD_VERT) begin
                first_line_vsize_out  <= rx[1:0];
                second_line_vsize_out <= rx[3:2];
            end
            if (second_unit && cmd == osdcd_pkg::OSDCD_VERT) begin
                vertical_start_out      <= {rx[5:0], 1'b0};
                crystal_rate_select_out <= rx[osdcd_pkg::SEL_BIT];
            end
            if (first_unit && rx_id == osdcd_pkg::OSDCD_HORZ) begin
                first_line_hsize_out  <= rx[1:0];
                second_line_hsize_out <= rx[3:2];
            end
            if (second_unit && cmd == osdcd_pkg::OSDCD_HORZ) begin
                horizontal_start_out <= {rx[5:0], 1'b0};
                dot_clock_select_out <= rx[osdcd_pkg::SEL_BIT];
            end
        end
    end

    // ==========================================================
    // Display control and sync mode
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in || (ce_in && soft_rst)) begin
            osc_stop_enable_out     <= 1'b0;
            test_mode_bit_out       <= 1'b0;
            display_enable_out      <= 1'b0;
            reverse_enable_out      <= 1'b0;
            blink_enable_out        <= 1'b0;
            blink_period_select_out <= 1'b0;
            blank_area_out          <= 2'h0;
            blank_video_select_out  <= 1'b0;
            int_sync_out            <= 1'b0;
            noninterlace_out        <= 1'b0;
            tv_standard_out         <= 2'h0;
        end else if (ce_in) begin
            if (first_unit && rx_id == osdcd_pkg::OSDCD_CTRL) begin
                osc_stop_enable_out <= rx[osdcd_pkg::OSC_STOP_BIT];
                test_mode_bit_out   <= rx[osdcd_pkg::TEST_BIT];
                if (rx[osdcd_pkg::ERASE_BIT]) begin
                    display_enable_out <= 1'b0;
                end
            end
            if (second_unit && cmd == osdcd_pkg::OSDCD_CTRL) begin
                display_enable_out      <= rx[osdcd_pkg::DISP_BIT] && !erase_busy_out;
                reverse_enable_out      <= rx[osdcd_pkg::REV_BIT];
                blink_enable_out        <= rx[osdcd_pkg::BLINK_BIT];
                blink_period_select_out <= rx[osdcd_pkg::PERIOD_BIT];
                blank_area_out          <= rx[osdcd_pkg::BLANK_LSB +: 2];
                blank_video_select_out  <= rx[osdcd_pkg::VIDEO_BIT];
            end
            if (first_unit && rx_id == osdcd_pkg::OSDCD_SYNC) begin
                int_sync_out     <= rx[osdcd_pkg::INT_SYNC_BIT];
                noninterlace_out <= rx[osdcd_pkg::NONINT_BIT];
                tv_standard_out  <= rx[osdcd_pkg::STD_LSB +: 2];
            end
        end
    end

    // ==========================================================
    // Display memory erase and writes
    logic [15:0] erase_cnt;
    logic        mem_we;
    logic [8:0]  mem_wa;
    logic [7:0]  mem_wd;
    logic [7:0]  vram [0:287];

    // The fill ends after the first words; the rest of the time only
    // keeps the busy flag up for the host's documented wait.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            erase_busy_out <= 1'b0;
            erase_cnt      <= 16'h0000;
        end else if (ce_in) begin
            if (erase_go && !erase_busy_out) begin
                erase_busy_out <= 1'b1;
                erase_cnt      <= 16'h0000;
            end else if (erase_busy_out) begin
                erase_cnt <= erase_cnt + 16'h0001;
                if (erase_cnt == 16'(ERASE_CYC - 1)) begin
                    erase_busy_out <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        if (erase_busy_out) begin
            mem_we = erase_cnt < {7'h00, osdcd_pkg::MEM_WORDS};
            mem_wa = erase_cnt[8:0];
            mem_wd = osdcd_pkg::BLANK_WORD;
        end else begin
            mem_we = char_wr && addr_ok(row_addr_out, col_addr_out);
            mem_wa = mem_addr(row_addr_out, col_addr_out);
            mem_wd = rx;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (ce_in && mem_we) begin
            vram[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else if (ce_in) begin
            rd_data_out <= (rd_addr_in < osdcd_pkg::MEM_WORDS) ? vram[rd_addr_in]
                           : osdcd_pkg::BLANK_WORD;
        end
    end

    // ==========================================================
    // Blink timer
    logic [25:0] blink_cnt;
    logic [25:0] blink_half;

    assign blink_half = blink_period_select_out ? 26'(BLINK_LONG - 1)
                        : 26'(BLINK_SHORT - 1);

    // The phase drives the normal and inverse alternation of blinking
    // reverse characters in the video logic.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            blink_cnt       <= 26'h000_0000;
            blink_phase_out <= 1'b0;
        end else if (ce_in) begin
            if (!blink_enable_out) begin
                blink_cnt       <= 26'h000_0000;
                blink_phase_out <= 1'b0;
            end else if (blink_cnt >= blink_half) begin
                blink_cnt       <= 26'h000_0000;
                blink_phase_out <= ~blink_phase_out;
            end else begin
                blink_cnt <= blink_cnt + 26'h000_0001;
            end
        end
    end

    // ==========================================================
    // Checks
    sequence s_erase_start;
        erase_go && !erase_busy_out;
    endsequence
    sequence s_erase_run;
        (erase_busy_out && !display_enable_out) [*8];
    endsequence

    a_enable_revert: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        ce_in && cs_s2 |=> cmd == osdcd_pkg::OSDCD_ADDR
    ) else $error("command not reverted while enable high");
    a_cmd_kept: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        ce_in && !cs_s2 && !first_unit |=> cmd == $past(cmd)
    ) else $error("command changed without a first unit");
    a_row_take: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        first_unit && rx_id == osdcd_pkg::OSDCD_ADDR |=> row_addr_out == $past(rx[3:0])
    ) else $error("row address not taken");
    a_col_take: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        second_unit && cmd == osdcd_pkg::OSDCD_ADDR |=> col_addr_out == $past(rx[4:0])
    ) else $error("column address not taken");
    a_char_mode: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        cmd == osdcd_pkg::OSDCD_CHAR && ce_in && !cs_s2 |=> cmd == osdcd_pkg::OSDCD_CHAR
    ) else $error("character mode left while enable low");
    a_col_step: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        char_wr && !erase_busy_out && col_addr_out < osdcd_pkg::COL_LAST
        |=> col_addr_out == $past(col_addr_out) + 5'h01
    ) else $error("column did not advance");
    a_start_double: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        second_unit && cmd == osdcd_pkg::OSDCD_VERT && !soft_rst
        |=> vertical_start_out == {$past(rx[5:0]), 1'b0}
            && crystal_rate_select_out == $past(rx[6])
    ) else $error("vertical start or crystal rate wrong");
    a_dot_select: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        second_unit && cmd == osdcd_pkg::OSDCD_HORZ
        |=> dot_clock_select_out == $past(rx[6])
            && horizontal_start_out == {$past(rx[5:0]), 1'b0}
    ) else $error("horizontal start or dot clock wrong");
    a_soft_reset: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        soft_rst |=> !display_enable_out && vertical_start_out == 7'h00
                     && tv_standard_out == 2'h0 && row_addr_out == 4'h0
    ) else $error("soft reset left a field set");
    a_hard_reset: assert property (
        @(posedge core_clk_in)
        $fell(rst_in) |-> !display_enable_out && horizontal_start_out == 7'h00
                          && blank_area_out == 2'h0 && cmd == osdcd_pkg::OSDCD_ADDR
    ) else $error("field not cleared by reset");
    a_erase_fill: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        s_erase_start ##1 ce_in [*8] |-> s_erase_run
    ) else $error("erase did not hold display off");
    a_erase_write: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        erase_busy_out && erase_cnt < 16'h0120 |-> mem_we && mem_wd == 8'h7F
    ) else $error("erase did not write blank code");

endmodule

/* File: shared/osdcd_pkg.sv */
// Constants, command codes and field layout of the serial command decoder.
package osdcd_pkg;

    typedef enum logic [2:0] {
        OSDCD_ADDR = 3'h0,
        OSDCD_CHAR = 3'h1,
        OSDCD_VERT = 3'h2,
        OSDCD_HORZ = 3'h3,
        OSDCD_CTRL = 3'h4,
        OSDCD_SYNC = 3'h5,
        OSDCD_SIGC = 3'h6,
        OSDCD_PORT = 3'h7
    } osdcd_cmd_e;

    localparam int          UNIT_FLAG_BIT = 7;
    localparam int          ID_MSB        = 6;
    localparam int          ID_LSB        = 4;
    localparam int          SEL_BIT       = 6;
    localparam int          SRST_BIT      = 0;
    localparam int          OSC_STOP_BIT  = 1;
    localparam int          ERASE_BIT     = 2;
    localparam int          TEST_BIT      = 3;
    localparam int          DISP_BIT      = 0;
    localparam int          REV_BIT       = 1;
    localparam int          BLINK_BIT     = 2;
    localparam int          PERIOD_BIT    = 3;
    localparam int          BLANK_LSB     = 4;
    localparam int          VIDEO_BIT     = 6;
    localparam int          INT_SYNC_BIT  = 0;
    localparam int          NONINT_BIT    = 1;
    localparam int          STD_LSB       = 2;
    localparam logic [3:0]  ROW_LAST      = 4'hB;
    localparam logic [4:0]  COL_LAST      = 5'h17;
    localparam logic [8:0]  ROW_WORDS     = 9'h018;
    localparam logic [8:0]  MEM_WORDS     = 9'h120;
    localparam logic [7:0]  BLANK_WORD    = 8'h7F;
    localparam logic [7:0]  FIELD_RESET   = 8'h00;
    localparam int          CLK_MHZ       = 100;
    localparam int          ERASE_TIME_US = 500;
    localparam int          ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
    localparam int          BLINK_SHORT_MS = 500;
    localparam int          BLINK_LONG_MS  = 1000;
    localparam int          BLINK_SHORT_HALF = BLINK_SHORT_MS * CLK_MHZ * 1000 / 2;
    localparam int          BLINK_LONG_HALF  = BLINK_LONG_MS * CLK_MHZ * 1000 / 2;

endpackage

/* File: test/osdcd_host.sv */
// Host model that frames and shifts command units into the serial port.
`timescale 1ns/10ps
module osdcd_host (
    // Serial command pins
    output logic link_clk_out,
    output logic cs_n_out,
    output logic sdata_out
);
    // The link clock stands still between frames and the data line idles at its pull-up level.
    initial begin
        link_clk_out = 1'b0;
        cs_n_out     = 1'b1;
        sdata_out    = 1'b1;
    end

    task automatic shift(input logic [7:0] unit);
        for (int i = 7; i >= 0; i--) begin
            sdata_out = unit[i];
            #6 link_clk_out = 1'b1;
            #6 link_clk_out = 1'b0;
        end
    endtask

    task automatic frame(input logic [7:0] u0, u1, u2, input int n);
        cs_n_out = 1'b0;
        #20;
        shift(u0);
        if (n > 1) shift(u1);
        if (n > 2) shift(u2);
        #20 cs_n_out = 1'b1;
        sdata_out = 1'b1;
    endtask
endmodule

/* File: test/osdcd_top_test.sv */
// Self-checking bench of the serial command decoder.
`timescale 1ns/10ps
module osdcd_top_test;
    logic        core_clk_in = 1'b0;
    logic        rst_in      = 1'b1;
    logic        ce_in       = 1'b1;
    logic [8:0]  rd_addr_in  = 9'h000;
    logic        link_clk_in, cs_n_in, sdata_in;
    logic [7:0]  rd_data_out;
    logic [3:0]  row_addr_out;
    logic [4:0]  col_addr_out;
    logic [6:0]  vertical_start_out, horizontal_start_out;
    logic [1:0]  first_line_vsize_out, second_line_vsize_out, first_line_hsize_out;
    logic [1:0]  second_line_hsize_out, blank_area_out, tv_standard_out;
    logic        crystal_rate_select_out, dot_clock_select_out, osc_stop_enable_out;
    logic        test_mode_bit_out, display_enable_out, reverse_enable_out, blink_enable_out;
    logic        blink_period_select_out, blank_video_select_out, blink_phase_out;
    logic        erase_busy_out, int_sync_out, noninterlace_out;
    logic [46:0] e, fields;
    logic [46:0] q [$];
    logic [7:0]  mq [$];
    logic [7:0]  mem [288];
    logic [3:0]  r;
    logic [2:0]  id = 3'h0;
    int          num_errors = 0, samples_checked = 0, cycles = 0;
    logic        bq [$];
    event        f_ev, m_ev, b_ev;

    osdcd_host u_osdcd_host (.link_clk_out(link_clk_in), .cs_n_out(cs_n_in), .sdata_out(sdata_in));
    osdcd_top #(.ERASE_CYC(300), .BLINK_SHORT(10), .BLINK_LONG(20)) u_osdcd_top (
        .core_clk_in, .rst_in, .ce_in, .link_clk_in, .cs_n_in, .sdata_in, .rd_addr_in,
        .rd_data_out, .row_addr_out, .col_addr_out, .first_line_vsize_out, .second_line_vsize_out,
        .vertical_start_out, .crystal_rate_select_out, .first_line_hsize_out,
        .second_line_hsize_out, .horizontal_start_out, .dot_clock_select_out,
        .osc_stop_enable_out, .test_mode_bit_out, .display_enable_out, .reverse_enable_out,
        .blink_enable_out, .blink_period_select_out, .blank_area_out, .blank_video_select_out,
        .blink_phase_out, .erase_busy_out, .int_sync_out, .noninterlace_out, .tv_standard_out);

    assign fields = {row_addr_out, col_addr_out, first_line_vsize_out, second_line_vsize_out,
        vertical_start_out, crystal_rate_select_out, first_line_hsize_out, second_line_hsize_out,
        horizontal_start_out, dot_clock_select_out, osc_stop_enable_out, test_mode_bit_out,
        display_enable_out, reverse_enable_out, blink_enable_out, blink_period_select_out,
        blank_area_out, blank_video_select_out, int_sync_out, noninterlace_out, tv_standard_out,
        erase_busy_out};

    always #5 core_clk_in = ~core_clk_in;

    // ==========================================
    // Reference model of the command fields
    task automatic model(input logic [7:0] u);
        if (id == 3'h1) begin
            if (!e[0]) begin
                mem[24 * int'(e[46:43]) + int'(e[42:38])] = u;
                if (e[42:38] == 5'h17) e[46:38] = {(e[46:43] == 4'hB) ? 4'h0 : e[46:43] + 4'h1, 5'h00};
                else e[42:38] = e[42:38] + 5'h01;
            end
        end else if (u[7]) begin
            id = u[6:4];
            case (id)
                3'h0: e[46:43] = u[3:0];
                3'h2: e[37:34] = {u[1:0], u[3:2]};
                3'h3: e[25:22] = {u[1:0], u[3:2]};
                3'h4: begin
                    if (u[0]) e = '0;
                    e[13:12] = {u[1], u[3]};
                    if (u[2]) begin
                        e[11] = 1'b0;
                        e[0] = 1'b1;
                        foreach (mem[a]) mem[a] = 8'h7F;
                    end
                end
                3'h5: e[4:1] = {u[0], u[1], u[3:2]};
                default: ;
            endcase
        end else begin
            case (id)
                3'h0: e[42:38] = u[4:0];
                3'h2: e[33:26] = {u[5:0], 1'b0, u[6]};
                3'h3: e[21:14] = {u[5:0], 1'b0, u[6]};
                3'h4: e[11:5] = {u[0] & !e[0], u[1], u[2], u[3], u[5:4], u[6]};
                default: ;
            endcase
        end
    endtask

    // ==========================================
    // Drivers, watchers and comparisons
    task automatic check;
        q.push_back(e);
        -> f_ev;
    endtask

    task automatic bcheck(input logic v);
        bq.push_back(v);
        -> b_ev;
    endtask

    task automatic mcheck(input int a);
        @(posedge core_clk_in);
        #1 rd_addr_in = 9'(a);
        repeat (2) @(posedge core_clk_in);
        #1 mq.push_back(mem[a]);
        -> m_ev;
    endtask

    task automatic run(input logic [7:0] u0, u1, u2, input int n);
        @(posedge core_clk_in);
        #1 u_osdcd_host.frame(u0, u1, u2, n);
        model(u0);
        if (n > 1) model(u1);
        if (n > 2) model(u2);
        id = 3'h0;
        repeat (8) @(posedge core_clk_in);
        #1 check();
    endtask

    task automatic compare_f(input logic [46:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t fields got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic compare_m(input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t memory got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic compare_b(input logic got, exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t blink phase got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial forever begin
        @(f_ev);
        compare_f(fields, q.pop_front());
    end

    initial forever begin
        @(m_ev);
        compare_m(rd_data_out, mq.pop_front());
    end

    initial forever begin
        @(b_ev);
        compare_b(blink_phase_out, bq.pop_front());
    end

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(8469));
        e = '0;
        repeat (6) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        repeat (4) @(posedge core_clk_in);
        #1 check();
        r = 4'($urandom_range(10, 0));
        run({4'h8, r}, 8'h16, 8'h00, 2);
        run(8'h90, 8'($urandom), 8'($urandom), 3);
        mcheck(24 * r + 22);
        mcheck(24 * r + 23);
        run(8'h0B, 8'h00, 8'h00, 1);
        for (int k = 2; k < 4; k++) begin
            run({1'b1, 3'(k), 4'($urandom)}, {1'b0, 7'($urandom)}, {1'b0, 7'($urandom)}, 3);
        end
        repeat (4) run({6'h30, 1'($urandom), 1'b0}, {1'b0, 7'($urandom)}, 8'h00, 2);
        for (int k = 0; k < 4; k++) run({4'hD, 2'(k), 2'($urandom)}, 8'h00, 8'h00, 1);
        // The phase must stand for half periods of 10 and 20 cycles, as set at the instance.
        for (int p = 0; p < 2; p++) begin
            run(8'hC0, {4'h0, 1'(p), 3'h4}, 8'h00, 2);
            @(posedge blink_phase_out);
            repeat (p * 10 + 9) @(posedge core_clk_in);
            #1 bcheck(1'b1);
            @(posedge core_clk_in);
            #1 bcheck(1'b0);
        end
        run(8'hC0, 8'h01, 8'h00, 2);
        run(8'hC4, 8'h00, 8'h00, 1);
        repeat (300) @(posedge core_clk_in);
        e[0] = 1'b0;
        #1 check();
        mcheck(24 * r + 22);
        run(8'hC1, 8'h00, 8'h00, 1);
        run({4'h8, r}, 8'h05, 8'h00, 2);
        rst_in = 1'b1;
        @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        e = '0;
        repeat (2) @(posedge core_clk_in);
        #1 check();
        #1 complete_run();
    end
endmodule
